// [rtl/blt_pkg.sv]
package blt_pkg;
	localparam int          REG_W            = 8;
	localparam int          ADDR_W           = 12;
	localparam int          MAX_BANKS        = 4;
	localparam int          PAT_LEN          = 8;
	localparam int          CLOCK_PERIOD_NS  = 25;
	localparam int          FUSE_LOAD_NS     = 10000;
	localparam int          FUSE_LOAD_CYCLES = (FUSE_LOAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int          LINK_TIMEOUT_NS  = 1000;
	localparam int          LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLOCK_PERIOD_NS;
	localparam int          STICKY_REVISION  = 2;
	// Register offsets
	localparam logic [11:0] OFS_CONTROL      = 12'h010;
	localparam logic [11:0] OFS_CONFIG       = 12'h011;
	localparam logic [11:0] OFS_BUF_DELAY    = 12'h012;
	localparam logic [11:0] OFS_STATUS       = 12'h013;
	localparam logic [11:0] OFS_ALARM        = 12'h014;
	localparam logic [11:0] OFS_OSC_FREQ     = 12'h015;
	localparam logic [11:0] OFS_OSC_PHASE    = 12'h016;
	localparam logic [11:0] OFS_TEST_CTRL    = 12'h020;
	localparam logic [11:0] OFS_TEST_STATUS  = 12'h021;
	localparam logic [11:0] OFS_TEST_FAIL_AT = 12'h022;
	localparam logic [11:0] OFS_TEST_FAIL_D  = 12'h023;
	localparam logic [11:0] OFS_PATTERN      = 12'h028;
	localparam logic [11:0] OFS_EDGE_MAP     = 12'h030;
	localparam logic [11:0] OFS_FUSE_STATUS  = 12'h900;
	localparam logic [11:0] OFS_STICKY_CTRL  = 12'hb02;
	// Field positions
	localparam int          CTL_DATAPATH_ENABLE        = 0;
	localparam int          CTL_STROBE_ALIGN = 1;
	localparam int          CTL_REF_ALIGN    = 2;
	localparam int          CTL_OSC_EN       = 3;
	localparam int          CTL_OSC_CHG_BLK  = 4;
	localparam int          CTL_OSC_SYNC_SRC = 5;
	localparam int          CTL_TX_A         = 6;
	localparam int          CTL_TX_B         = 7;
	localparam int          CFG_DCM          = 2;
	localparam int          ST_STROBE_DET    = 0;
	localparam int          ST_REF_DET       = 1;
	localparam int          ALM_CLK          = 0;
	localparam int          ALM_STROBE       = 1;
	localparam int          ALM_REALIGN      = 2;
	localparam int          TC_ENABLE        = 0;
	localparam int          TC_CONT          = 1;
	localparam int          TC_STRB_LOCK     = 2;
	localparam int          TC_TRIGGER       = 3;
	localparam int          TC_MASK_LSB      = 4;
	localparam int          FUSE_DONE_BIT    = 0;
	localparam int          STICKY_EN_BIT    = 0;
	// Reset values
	localparam logic [7:0]  RST_REG          = 8'h00;

	typedef struct packed {
		logic       enable;
		logic       continuous;
		logic       strobe_lock;
		logic [3:0] mask;
		logic [3:0] used;
	} blt_test_cfg_type;
endpackage

// [rtl/blt_link_checker.sv]
`timescale 1ns/10ps
module blt_link_checker
	import blt_pkg::*;
#(
	parameter int NUM_BANKS = 4
) (
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire blt_test_cfg_type             cfg,
	input  wire logic                         trigger,
	input  wire logic                         sample_valid,
	input  wire logic [2:0]                   sample_index,
	input  wire logic [NUM_BANKS*REG_W-1:0]   samples,
	input  wire logic [PAT_LEN*REG_W-1:0]     pattern,
	output logic                              running,
	output logic                              summary,
	output logic [NUM_BANKS-1:0]              line_miss,
	output logic [7:0]                        fail_at,
	output logic [7:0]                        fail_data
);
	logic [NUM_BANKS-1:0] bank_fail;
	logic [NUM_BANKS-1:0] active;
	logic [REG_W-1:0]     expected;
	logic [1:0]           first_bank;
	logic                 any_fail;

	assign expected = pattern[sample_index*REG_W +: REG_W];
	assign active   = ~cfg.mask[NUM_BANKS-1:0] & cfg.used[NUM_BANKS-1:0];

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_cmp
			// Masked or unused banks never record
			assign bank_fail[b] = sample_valid && running && active[b]
				&& (samples[b*REG_W +: REG_W] != expected);
		end
	endgenerate

	assign any_fail = |bank_fail;

	always_comb begin
		first_bank = '0;
		for (int i = NUM_BANKS - 1; i >= 0; i--) begin
			if (bank_fail[i]) begin
				first_bank = 2'(i);
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			running   <= 1'b0;
			summary   <= 1'b0;
			line_miss <= '0;
			fail_at   <= 8'h00;
			fail_data <= 8'h00;
		end else if (trigger) begin
			running   <= cfg.enable;
			summary   <= 1'b0;
			line_miss <= '0;
		end else if (any_fail) begin
			summary   <= 1'b1;
			line_miss <= line_miss | bank_fail;
			if (!cfg.continuous) begin
				// Stop on first failure, freeze the failing frame
				running   <= 1'b0;
				fail_at   <= {2'b00, first_bank, 1'b0, sample_index};
				fail_data <= samples[first_bank*REG_W +: REG_W];
			end
		end else if (!cfg.enable) begin
			running   <= 1'b0;
		end
	end
endmodule

// [rtl/blt_bringup_ctrl.sv]
`timescale 1ns/10ps
// Functional notes
// - Fuse status bit 0 reads 1 once fuse loading finished; resets to 0.
// - Fuse loading starts by itself when reset is released.
// - Sticky enable set: edge map accumulates every detected reference edge position.
// - Sticky enable clear: edge map shows only the latest reference edge position.
// - Sticky function exists only when chip revision equals 2.
// - Transmission starts from transmit pin or per-channel enable bits; code also gates it with datapath enable (control bit 0).
// - With oscillator disabled, frequency and phase writes take effect directly.
// - Oscillator-only runs unaligned; reference edges align only when align enabled.
// - After oscillator enable, accumulators sync from the selected source.
// - Link test compares received samples against the eight-sample pattern.
// - Continuous 0 stops on failure; continuous 1 keeps running, updates flags.
// - Masked input banks record no link test failures.
// - Link test checks only banks used by channel config and dual mode.
module blt_bringup_ctrl
	import blt_pkg::*;
#(
	parameter int NUM_BANKS     = 4,
	parameter int CHIP_REVISION = 2
) (
	input  wire logic                       clock,
	input  wire logic                       resetn,
	input  wire logic [ADDR_W-1:0]          reg_addr,
	input  wire logic [REG_W-1:0]           reg_wdata,
	input  wire logic                       reg_write,
	input  wire logic                       reg_read,
	output logic      [REG_W-1:0]           reg_rdata,
	input  wire logic                       link_clock,
	input  wire logic [NUM_BANKS*REG_W-1:0] link_data,
	input  wire logic                       link_strobe,
	input  wire logic                       reference_edge,
	input  wire logic                       transmit_enable_pin,
	input  wire logic                       sync_request_low,
	output logic                            fuse_load_done,
	output logic                            transmit_active,
	output logic [1:0]                      channel_transmit,
	output logic [REG_W-1:0]                osc_frequency,
	output logic [REG_W-1:0]                osc_phase,
	output logic                            osc_sync_pulse,
	output logic [2:0]                      frame_position,
	output logic [3:0]                      elastic_buffer_delay
);
	initial begin
		if (NUM_BANKS < 1 || NUM_BANKS > MAX_BANKS) begin
			$error("NUM_BANKS out of range");
		end
	end

	// Pin synchronisers: 2 flops each before any logic
	localparam int SYNC_W = NUM_BANKS * REG_W + 5;
	logic [SYNC_W-1:0] pin_s1;
	logic [SYNC_W-1:0] pin_s2;
	logic              link_clock_d;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_s1       <= '0;
			pin_s2       <= '0;
			link_clock_d <= 1'b0;
		end else begin
			pin_s1       <= {link_data, link_strobe, reference_edge,
				transmit_enable_pin, sync_request_low, link_clock};
			pin_s2       <= pin_s1;
			link_clock_d <= pin_s2[0];
		end
	end

	wire [NUM_BANKS*REG_W-1:0] data_s = pin_s2[SYNC_W-1:5];
	wire strobe_s    = pin_s2[4];
	wire ref_s       = pin_s2[3];
	wire tx_pin_s    = pin_s2[2];
	wire link_clk_s  = pin_s2[0];
	wire link_edge   = link_clk_s ^ link_clock_d;
	wire link_rise   = link_clk_s & ~link_clock_d;

	// Registers
	logic [7:0]       control;
	logic [7:0]       config_reg;
	logic [3:0]       buf_delay;
	logic [1:0]       status;
	logic [2:0]       alarm;
	logic [7:0]       osc_freq_stage;
	logic [7:0]       osc_phase_stage;
	logic [7:0]       test_ctrl;
	logic [7:0]       pattern [PAT_LEN];
	logic             sticky_en;
	logic [7:0]       edge_map;
	logic             strobe_d;
	logic             ref_d;
	logic [2:0]       sample_index;
	logic [7:0]       pos_count;
	logic [7:0]       link_idle;
	logic [15:0]      fuse_count;
	logic             osc_en_d;
	logic             osc_pending;
	logic             link_running;

	// Decode
	wire wr_control  = reg_write && reg_addr == OFS_CONTROL;
	wire wr_config   = reg_write && reg_addr == OFS_CONFIG;
	wire wr_delay    = reg_write && reg_addr == OFS_BUF_DELAY;
	wire wr_status   = reg_write && reg_addr == OFS_STATUS;
	wire wr_alarm    = reg_write && reg_addr == OFS_ALARM;
	wire wr_freq     = reg_write && reg_addr == OFS_OSC_FREQ;
	wire wr_phase    = reg_write && reg_addr == OFS_OSC_PHASE;
	wire wr_test     = reg_write && reg_addr == OFS_TEST_CTRL;
	wire wr_sticky   = reg_write && reg_addr == OFS_STICKY_CTRL;
	wire wr_pattern  = reg_write && reg_addr[11:3] == OFS_PATTERN[11:3];
	wire trigger     = wr_test && reg_wdata[TC_TRIGGER];

	// Sticky function only on the revision that carries it
	localparam logic STICKY_PRESENT = (CHIP_REVISION == STICKY_REVISION);

	wire datapath_enable       = control[CTL_DATAPATH_ENABLE];
	wire osc_en      = control[CTL_OSC_EN];
	wire strobe_rise = strobe_s & ~strobe_d & link_edge;
	wire ref_rise    = ref_s & ~ref_d;
	// Oscillator-only: no realign unless alignment is enabled
	wire ref_align   = ref_rise && control[CTL_REF_ALIGN];
	wire strobe_lock = test_ctrl[TC_STRB_LOCK] && link_running;
	wire strobe_align = strobe_rise && control[CTL_STROBE_ALIGN] && !strobe_lock;
	wire realign     = (ref_align || strobe_align) && sample_index != 3'd0;
	wire sample_ok   = datapath_enable && link_edge;
	wire [7:0] edge_hit = 8'h01 << pos_count[2:0];

	// Oscillator settings pass through while disabled or unblocked
	wire osc_load    = !osc_en || !control[CTL_OSC_CHG_BLK];
	// Sync source 0: enable edge; source 1: next reference edge
	wire osc_rise    = osc_en && !osc_en_d;
	wire osc_fire    = control[CTL_OSC_SYNC_SRC] ? (osc_pending && ref_rise) : osc_rise;

	function automatic logic [3:0] used_banks(input logic [1:0] cfg, input logic dcm);
		logic [3:0] r;
		r = 4'hf;
		if (!dcm) begin
			unique case (cfg)
				2'd0:    r = 4'h3;
				2'd1:    r = 4'hc;
				default: r = 4'hf;
			endcase
		end
		return r;
	endfunction

	// Link test
	blt_test_cfg_type     test_cfg;
	logic                 link_summary;
	logic [NUM_BANKS-1:0] link_miss;
	logic [7:0]           fail_at;
	logic [7:0]           fail_data;
	logic [PAT_LEN*REG_W-1:0] pattern_flat;

	genvar p;
	generate
		for (p = 0; p < PAT_LEN; p++) begin : g_pat
			assign pattern_flat[p*REG_W +: REG_W] = pattern[p];
		end
	endgenerate

	assign test_cfg = '{
		enable:      test_ctrl[TC_ENABLE],
		continuous:  test_ctrl[TC_CONT],
		strobe_lock: test_ctrl[TC_STRB_LOCK],
		mask:        test_ctrl[7:TC_MASK_LSB],
		used:        used_banks(config_reg[1:0], config_reg[CFG_DCM])
	};

	blt_link_checker #(
		.NUM_BANKS (NUM_BANKS)
	) u_checker (
		.clock        (clock),
		.resetn       (resetn),
		.cfg          (test_cfg),
		.trigger      (trigger),
		.sample_valid (sample_ok),
		.sample_index (sample_index),
		.samples      (data_s),
		.pattern      (pattern_flat),
		.running      (link_running),
		.summary      (link_summary),
		.line_miss    (link_miss),
		.fail_at      (fail_at),
		.fail_data    (fail_data)
	);

	// Control registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			control         <= RST_REG;
			config_reg      <= RST_REG;
			buf_delay       <= '0;
			osc_freq_stage  <= RST_REG;
			osc_phase_stage <= RST_REG;
			test_ctrl       <= RST_REG;
			sticky_en       <= 1'b0;
			for (int i = 0; i < PAT_LEN; i++) begin
				pattern[i] <= RST_REG;
			end
		end else begin
			if (wr_control) control <= reg_wdata;
			if (wr_config) config_reg <= reg_wdata;
			if (wr_delay) buf_delay <= reg_wdata[3:0];
			if (wr_freq) osc_freq_stage <= reg_wdata;
			if (wr_phase) osc_phase_stage <= reg_wdata;
			if (wr_test) test_ctrl <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
			// Bit 3 is the trigger and is not stored
			if (wr_sticky) sticky_en <= reg_wdata[STICKY_EN_BIT] & STICKY_PRESENT;
			if (wr_pattern) pattern[reg_addr[2:0]] <= reg_wdata;
		end
	end

	// Status, alarms and edge map: hardware set beats software clear
	wire [1:0] status_set = {ref_align, strobe_align};
	wire [2:0] alarm_set;
	assign alarm_set[ALM_CLK]     = datapath_enable && link_idle == 8'(LINK_TIMEOUT_CYC);
	assign alarm_set[ALM_STROBE]  = datapath_enable && strobe_rise && !control[CTL_STROBE_ALIGN]
		&& sample_index != 3'd0;
	assign alarm_set[ALM_REALIGN] = realign;
	wire sticky_start = wr_sticky && reg_wdata[STICKY_EN_BIT] && !sticky_en;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status   <= '0;
			alarm    <= '0;
			edge_map <= 8'h00;
		end else begin
			status <= (status & ~(wr_status ? reg_wdata[1:0] : 2'b00)) | status_set;
			alarm  <= (alarm & ~(wr_alarm ? reg_wdata[2:0] : 3'b000)) | alarm_set;
			if (ref_rise) begin
				// Accumulate or replace per sticky enable
				edge_map <= (sticky_en && !sticky_start) ? (edge_map | edge_hit) : edge_hit;
			end else if (sticky_start) begin
				edge_map <= 8'h00;
			end
		end
	end

	// Link clock phase tracking and frame position
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strobe_d     <= 1'b0;
			ref_d        <= 1'b0;
			sample_index <= '0;
			pos_count    <= 8'h00;
			link_idle    <= 8'h00;
		end else begin
			// Strobe is judged sample to sample; it settles before the link edge
			if (link_edge) strobe_d <= strobe_s;
			ref_d     <= ref_s;
			pos_count <= link_rise ? 8'h00 : (pos_count == 8'hff ? pos_count : pos_count + 8'h01);
			link_idle <= (link_edge || !datapath_enable) ? 8'h00
				: (link_idle == 8'hff ? link_idle : link_idle + 8'h01);
			if (ref_align) begin
				sample_index <= 3'd0;
			end else if (strobe_align) begin
				// Strobe marks sample 0, so the next sample is 1
				sample_index <= 3'd1;
			end else if (sample_ok) begin
				sample_index <= sample_index + 3'd1;
			end
		end
	end

	// Fuse load starts at reset release, no command needed
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fuse_count     <= '0;
			fuse_load_done <= 1'b0;
		end else if (fuse_count != 16'(FUSE_LOAD_CYCLES)) begin
			fuse_count     <= fuse_count + 16'd1;
		end else begin
			fuse_load_done <= 1'b1;
		end
	end

	// Oscillator
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			osc_frequency  <= RST_REG;
			osc_phase      <= RST_REG;
			osc_en_d       <= 1'b0;
			osc_pending    <= 1'b0;
			osc_sync_pulse <= 1'b0;
		end else begin
			osc_en_d       <= osc_en;
			osc_sync_pulse <= osc_fire;
			osc_pending    <= osc_en && !osc_fire && (osc_pending || osc_rise);
			if (osc_load) begin
				osc_frequency <= osc_freq_stage;
				osc_phase     <= osc_phase_stage;
			end
		end
	end

	// Transmit from pin or register bits
	assign channel_transmit     = datapath_enable ? (control[CTL_TX_B:CTL_TX_A] | {2{tx_pin_s}}) : 2'b00;
	assign transmit_active      = |channel_transmit;
	assign frame_position       = sample_index;
	assign elastic_buffer_delay = buf_delay;

	// Read mux
	logic [7:0] read_mux;
	wire  [3:0] miss_wide = 4'(link_miss);
	always_comb begin
		read_mux = 8'h00;
		unique case (reg_addr)
			OFS_CONTROL:      read_mux = control;
			OFS_CONFIG:       read_mux = config_reg;
			OFS_BUF_DELAY:    read_mux = {4'h0, buf_delay};
			OFS_STATUS:       read_mux = {5'h00, transmit_active, status};
			OFS_ALARM:        read_mux = {5'h00, alarm};
			OFS_OSC_FREQ:     read_mux = osc_freq_stage;
			OFS_OSC_PHASE:    read_mux = osc_phase_stage;
			OFS_TEST_CTRL:    read_mux = test_ctrl;
			OFS_TEST_STATUS:  read_mux = {miss_wide, 2'b00, link_summary, link_running};
			OFS_TEST_FAIL_AT: read_mux = fail_at;
			OFS_TEST_FAIL_D:  read_mux = fail_data;
			OFS_EDGE_MAP:     read_mux = edge_map;
			OFS_FUSE_STATUS:  read_mux = {7'h00, fuse_load_done};
			OFS_STICKY_CTRL:  read_mux = {7'h00, sticky_en};
			default: begin
				if (reg_addr[11:3] == OFS_PATTERN[11:3]) begin
					read_mux = pattern[reg_addr[2:0]];
				end
			end
		endcase
	end

	// Data only in the cycle after the read strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_read ? read_mux : 8'h00;
		end
	end
endmodule

// [dv/blt_bringup_ctrl_asserts.sv]
`timescale 1ns/10ps
module blt_bringup_ctrl_asserts
	import blt_pkg::*;
#(
	parameter int NUM_BANKS     = 4,
	parameter int CHIP_REVISION = 2
) (
	input wire logic              clock,
	input wire logic              resetn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [REG_W-1:0]  reg_wdata,
	input wire logic              reg_write,
	input wire logic              reg_read,
	input wire logic [REG_W-1:0]  reg_rdata,
	input wire logic              fuse_load_done,
	input wire logic              transmit_active,
	input wire logic [1:0]        channel_transmit,
	input wire logic              osc_sync_pulse,
	input wire logic [2:0]        frame_position
);
	logic [15:0] fuse_cnt;
	logic        sticky_wbit;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// Saturates so a long run never wraps into a false early count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fuse_cnt <= 16'h0000;
		end else if (fuse_cnt != 16'hffff) begin
			fuse_cnt <= fuse_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sticky_wbit <= 1'b0;
		end else if (reg_write && reg_addr == OFS_STICKY_CTRL) begin
			sticky_wbit <= reg_wdata[STICKY_EN_BIT];
		end
	end

	property p_rdata_idle;
		!$past(reg_read) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
	property p_fuse_read;
		(reg_read && reg_addr == OFS_FUSE_STATUS) ##1 $stable(fuse_load_done)
			|-> reg_rdata == {7'h00, fuse_load_done};
	endproperty
	a_fuse_read: assert property (p_fuse_read) else $error("fuse status read wrong");
	property p_fuse_early;
		$rose(fuse_load_done) |-> fuse_cnt >= FUSE_LOAD_CYCLES;
	endproperty
	a_fuse_early: assert property (p_fuse_early) else $error("fuse done too early");
	property p_fuse_late;
		fuse_cnt == FUSE_LOAD_CYCLES + 3 |-> fuse_load_done;
	endproperty
	a_fuse_late: assert property (p_fuse_late) else $error("fuse load never finished");
	property p_fuse_hold;
		fuse_load_done |=> fuse_load_done;
	endproperty
	a_fuse_hold: assert property (p_fuse_hold) else $error("fuse done dropped");
	property p_transmit;
		reg_write && reg_addr == OFS_CONTROL && reg_wdata[CTL_DATAPATH_ENABLE] && reg_wdata[7:6] != 2'b00
			|=> transmit_active;
	endproperty
	a_transmit: assert property (p_transmit) else $error("transmit flags disagree");
	property p_sync_pulse;
		osc_sync_pulse |=> !osc_sync_pulse;
	endproperty
	a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
	property p_frame_step;
		frame_position != $past(frame_position)
			|-> frame_position == $past(frame_position) + 3'd1 || frame_position == 3'd0
			|| frame_position == 3'd1;
	endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame index skipped");
	property p_sticky;
		(reg_write && reg_addr == OFS_STICKY_CTRL) ##1 (reg_read && reg_addr == OFS_STICKY_CTRL)
			|=> reg_rdata[0] == ((CHIP_REVISION == 2) && sticky_wbit);
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky enable readback wrong");
endmodule

bind blt_bringup_ctrl blt_bringup_ctrl_asserts #(
	.NUM_BANKS(NUM_BANKS),
	.CHIP_REVISION(CHIP_REVISION)
) i_chk (
	.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.fuse_load_done, .transmit_active, .channel_transmit, .osc_sync_pulse, .frame_position
);

// [dv/blt_far_end.sv]
`timescale 1ns/10ps
module blt_far_end
	import blt_pkg::*;
#(
	parameter int NUM_BANKS = 4
) (
	input  wire logic                     run,
	input  wire logic [PAT_LEN*REG_W-1:0] pattern,
	input  wire logic [NUM_BANKS-1:0]     err_bank,
	input  wire logic                     send_ref,
	input  wire logic [2:0]               ref_pos,
	output logic                          link_clock,
	output logic [NUM_BANKS*REG_W-1:0]    link_data,
	output logic                          link_strobe,
	output logic                          reference_edge
);
	initial begin
		link_clock     = 1'b0;
		link_data      = '0;
		link_strobe    = 1'b0;
		reference_edge = 1'b0;
		forever begin
			if (!run) begin
				// Clock stands still; lines keep moving so stale data is never seen
				link_data = ~link_data;
				#200;
			end else begin
				for (int s = 0; s < PAT_LEN; s++) begin
					for (int b = 0; b < NUM_BANKS; b++) begin
						link_data[b*REG_W+:REG_W] = pattern[s*REG_W+:REG_W] ^ {REG_W{err_bank[b]}};
					end
					link_strobe    = (s == 0);
					reference_edge = send_ref && (s == ref_pos || s == ref_pos + 1);
					// Data settles half a bit before the clock edge that carries it
					#50;
					link_clock = ~link_clock;
					#50;
				end
			end
		end
	end
endmodule

// [dv/blt_bringup_ctrl_tb_top.sv]
`timescale 1ns/10ps
module blt_bringup_ctrl_tb_top
	import blt_pkg::*;
;
	logic                     clock;
	logic                     resetn;
	logic [ADDR_W-1:0]        reg_addr;
	logic [REG_W-1:0]         reg_wdata;
	logic                     reg_write;
	logic                     reg_read;
	logic [REG_W-1:0]         reg_rdata;
	logic                     link_clock;
	logic [4*REG_W-1:0]       link_data;
	logic                     link_strobe;
	logic                     reference_edge;
	logic                     transmit_enable_pin;
	logic                     sync_request_low;
	logic                     fuse_load_done;
	logic                     transmit_active;
	logic [1:0]               channel_transmit;
	logic [REG_W-1:0]         osc_frequency;
	logic [REG_W-1:0]         osc_phase;
	logic                     osc_sync_pulse;
	logic [2:0]               frame_position;
	logic [3:0]               elastic_buffer_delay;
	logic                     run;
	logic [PAT_LEN*REG_W-1:0] pattern;
	logic [3:0]               err_bank;
	logic                     send_ref;
	logic [2:0]               ref_pos;
	logic [REG_W-1:0]         q;
	logic [REG_W-1:0]         m1;
	logic [REG_W-1:0]         m2;
	logic [39:0]              tbl [6];
	int                       failures;
	int                       n_checks;

	blt_bringup_ctrl #(.NUM_BANKS(4), .CHIP_REVISION(2)) i_dut (
		.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.link_clock, .link_data, .link_strobe, .reference_edge, .transmit_enable_pin,
		.sync_request_low, .fuse_load_done, .transmit_active, .channel_transmit,
		.osc_frequency, .osc_phase, .osc_sync_pulse, .frame_position, .elastic_buffer_delay
	);
	blt_far_end #(.NUM_BANKS(4)) i_far (
		.run, .pattern, .err_bank, .send_ref, .ref_pos,
		.link_clock, .link_data, .link_strobe, .reference_edge
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic timeout(input logic ok);
		if (ok !== 1'b1) begin
			failures++;
			$display("[ERR] %0t wait ran out", $time);
			conclude();
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic wait_fuse();
		for (int i = 0; i < 500 && fuse_load_done !== 1'b1; i++) @(posedge clock);
		timeout(fuse_load_done);
		rd(OFS_FUSE_STATUS, q);
		chk(q, 8'h01, "fuse done");
	endtask
	task automatic capture_ref(input logic [2:0] p, output logic [7:0] m);
		ref_pos  <= p;
		send_ref <= 1'b1;
		repeat (64) @(posedge clock);
		send_ref <= 1'b0;
		repeat (40) @(posedge clock);
		rd(OFS_EDGE_MAP, m);
	endtask
	function automatic logic onehot(input logic [7:0] m);
		return (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00);
	endfunction

	initial begin
		{resetn, reg_write, reg_read, transmit_enable_pin, run, send_ref} = 6'h00;
		{reg_addr, reg_wdata, pattern, err_bank, ref_pos, q} = '0;
		sync_request_low = 1'b1;
		failures = 0;
		n_checks = 0;
		tbl = '{40'h04_0900_f301, 40'h04_0904_0302, 40'h04_4b06_f323,
			40'h00_0b0c_f301, 40'h00_0b01_f313, 40'h01_0b08_f383};
		void'($urandom(32'hc587));
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		rd(OFS_FUSE_STATUS, q);
		chk(q, 8'h00, "fuse busy");
		wait_fuse();
		rd(12'h7ff, q);
		chk(q, 8'h00, "unmapped read");
		for (int i = 0; i < PAT_LEN; i++) begin
			pattern[i*REG_W+:REG_W] = $urandom;
			wr(OFS_PATTERN + 12'(i), pattern[i*REG_W+:REG_W]);
		end
		run <= 1'b1;
		wr(OFS_CONFIG, 8'h04);
		wr(OFS_CONTROL, 8'h03);
		q = 8'h00;
		for (int i = 0; i < 100 && q[0] !== 1'b1; i++) rd(OFS_STATUS, q);
		timeout(q[0]);
		m1 = $urandom;
		m2 = $urandom;
		wr(OFS_OSC_FREQ, m1);
		wr(OFS_OSC_PHASE, m2);
		repeat (2) @(posedge clock);
		#1;
		chk(osc_frequency, m1, "osc freq direct");
		chk(osc_phase, m2, "osc phase direct");
		wr(OFS_CONTROL, 8'h0b);
		q = 8'h00;
		repeat (8) begin
			@(posedge clock);
			#1;
			q[0] = q[0] | (osc_sync_pulse === 1'b1);
		end
		chk(q, 8'h01, "osc sync pulse");
		wr(OFS_CONTROL, 8'h03);
		@(posedge clock);
		reg_addr  <= OFS_STICKY_CTRL;
		reg_wdata <= 8'h01;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read  <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, 8'h01, "sticky readback");
		capture_ref(3'd1, m1);
		capture_ref(3'd2, m2);
		chk(m2 & m1, m1, "sticky keeps old");
		chk(m2 === m1, 8'h00, "sticky adds new");
		wr(OFS_STICKY_CTRL, 8'h00);
		capture_ref(3'd1, m1);
		capture_ref(3'd2, m2);
		chk(onehot(m2), 8'h01, "latest edge only");
		chk(m2 & m1, 8'h00, "old edge dropped");
		send_ref <= 1'b1;
		wr(OFS_CONTROL, 8'h07);
		q = 8'h00;
		for (int i = 0; i < 100 && q[1] !== 1'b1; i++) rd(OFS_STATUS, q);
		timeout(q[1]);
		wr(OFS_CONTROL, 8'h03);
		send_ref <= 1'b0;
		wr(OFS_ALARM, 8'h07);
		wr(OFS_STATUS, 8'h03);
		repeat (100) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			transmit_enable_pin <= i[2];
			wr(OFS_CONTROL, {i[1], i[0], 6'h03});
			repeat (4) @(posedge clock);
			#1;
			chk(channel_transmit, {i[1] | i[2], i[0] | i[2]}, "channel tx");
			chk(transmit_active, i[2:0] != 3'd0, "tx active");
		end
		transmit_enable_pin <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			err_bank <= tbl[i][19:16];
			wr(OFS_CONFIG, tbl[i][39:32]);
			wr(OFS_TEST_CTRL, tbl[i][31:24] & 8'hf7);
			wr(OFS_CONTROL, 8'hc3);
			wr(OFS_TEST_CTRL, tbl[i][31:24]);
			repeat (128) @(posedge clock);
			rd(OFS_TEST_STATUS, q);
			chk(q & tbl[i][15:8], tbl[i][7:0], "link test status");
			if (i == 1) begin
				rd(OFS_TEST_FAIL_AT, q);
				chk(q[5:4], 8'h02, "fail bank");
				rd(OFS_TEST_FAIL_D, m1);
				chk(m1, pattern[q[2:0]*REG_W+:REG_W] ^ 8'hff, "fail data");
			end
		end
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk(fuse_load_done, 8'h00, "fuse done in reset");
		@(posedge clock);
		resetn <= 1'b1;
		rd(OFS_FUSE_STATUS, q);
		chk(q, 8'h00, "fuse restarted");
		wait_fuse();
		conclude();
	end
endmodule
